// ---- rtl/dhp_host_port.sv ----
// dual-style parallel host port: pin handshake, identity check, register access
//
// Behaviour
// RULE1 - port works only while port select pin is low; otherwise everything released
// RULE2 - any internal register reachable by 8-bit address, read and write
// RULE3 - data bus is 8 or 16 bits per control register; 8-bit uses low lines
// RULE4 - host supplies bus clock, slower than input port clock, under 100 MHz
// RULE5 - style pin low picks separate strobes, high picks single strobe
// RULE6 - separate style accesses happen on host clock rising edge, outside reset
// RULE7 - separate style: low read and write strobes; device drives data on reads
// RULE8 - separate style: ready held low during selected access, released when done
// RULE9 - ready and acknowledge are open drain, only ever pulled low
// RULE10 - host avoids addresses above map; device never completes those
// RULE11 - host write order: address, data, write strobe, select, wait ready
// RULE12 - separate style read: valid read data present once ready rises
// RULE13 - single style accesses happen on host clock rising edge, outside reset
// RULE14 - single style: direction high reads, low writes; strobe low marks valid
// RULE15 - acknowledge pulled low at completion, released on select or strobe high
// RULE16 - single style write completes with acknowledge a few clocks later
// RULE17 - single style read acknowledged once valid data is on the bus
// RULE18 - access completes only when identity field matches identity pins; control register writes complete on any identity
// RULE19 - output data words are readable through the same port
// RULE20 - data bus floats except while a selected read drives its data
`timescale 1ns/1ps
module dhp_host_port import dhp_pkg::*; #(
  parameter int ID_W = DHP_ID_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic port_select_pin,
  input wire logic bus_style_pin,
  input wire logic host_bus_clock,
  input wire logic chip_sel_n,
  input wire logic wr_n_or_dir,
  input wire logic rd_n_or_data_valid_strobe_n,
  input wire logic [DHP_ADDR_W-1:0] host_addr,
  input wire logic [DHP_DATA_W-1:0] data_in,
  output logic [DHP_DATA_W-1:0] data_out,
  output logic [DHP_DATA_W-1:0] data_oe,
  output logic transfer_acknowledge_out,
  output logic transfer_acknowledge_oe,
  input wire logic [ID_W-1:0] board_identity_pins,
  output logic core_req,
  output logic core_we,
  output logic [DHP_ADDR_W-1:0] core_addr,
  output logic [DHP_DATA_W-1:0] core_wdata,
  output logic core_wide,
  input wire logic core_ack,
  input wire logic [DHP_DATA_W-1:0] core_rdata
);

  if (ID_W < 1 || ID_W > DHP_HAC_WIDE_BIT - DHP_HAC_ID_LSB) begin : g_bad_id
    $error("dhp_host_port: identity width does not fit the access control register");
  end

  localparam int SYNC_W = DHP_DATA_W + DHP_ADDR_W + ID_W + 6;

  typedef struct packed {
    dhp_state_t st;
    logic prev_hclk;
    logic is_read;
    logic [7:0] hac;
    logic [DHP_ADDR_W-1:0] addr;
    logic [DHP_DATA_W-1:0] wdata;
    logic core_req;
    logic core_we;
    logic hs_out;
    logic hs_oe;
    logic [DHP_DATA_W-1:0] d_out;
    logic [DHP_DATA_W-1:0] d_oe;
  } dhp_regs_t;

  dhp_regs_t s;
  dhp_regs_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation; cs and strobes rest inactive so reset cannot start an access

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic psel_s;
  logic style_s;
  logic cs_n_s;
  logic strb_a_s;
  logic strb_b_s;
  logic hclk_s;
  logic [ID_W-1:0] ids_s;
  logic [DHP_ADDR_W-1:0] addr_s;
  logic [DHP_DATA_W-1:0] data_s;

  assign pins_raw = {data_in, host_addr, board_identity_pins, host_bus_clock,
                     rd_n_or_data_valid_strobe_n, wr_n_or_dir, chip_sel_n,
                     bus_style_pin, port_select_pin};

  dhp_sync #(
    .W(SYNC_W),
    .RST_VAL({{(SYNC_W-6){1'b0}}, 6'h1D})
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {data_s, addr_s, ids_s, hclk_s, strb_b_s, strb_a_s, cs_n_s, style_s, psel_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic port_on;
  logic single;
  logic hrise;
  logic req_valid;
  logic want_rd;
  logic id_ok;
  logic is_local;
  logic accept;
  logic wide;

  assign port_on = !psel_s; // RULE1
  assign single = (style_s == DHP_SINGLE_STROBE_STYLE); // RULE5
  // the host clock is only sampled; its rising edge paces every access
  assign hrise = hclk_s && !s.prev_hclk; // RULE6 RULE13
  assign wide = s.hac[DHP_HAC_WIDE_BIT]; // RULE3
  assign id_ok = (s.hac[DHP_HAC_ID_LSB +: ID_W] == ids_s); // RULE18
  assign is_local = (addr_s == DHP_HAC_OFFSET);
  // writes to the control register are taken by every chip, else no chip could be picked
  assign accept = id_ok || (is_local && !want_rd); // RULE18

  always_comb begin
    if (single) begin
      req_valid = !strb_b_s; // RULE14
      want_rd = strb_a_s; // RULE14
    end else begin
      // both strobes low is malformed and is not started
      req_valid = strb_a_s ^ strb_b_s; // RULE7
      want_rd = !strb_b_s; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control sequence

  always_comb begin
    next_s = s;
    next_s.prev_hclk = hclk_s;
    next_s.core_req = 1'b0;
    next_s.hs_out = 1'b0; // RULE9
    case (s.st)
      DHP_IDLE: begin
        next_s.hs_oe = 1'b0;
        next_s.d_oe = 16'h0000; // RULE20
        if (hrise && port_on && !cs_n_s && req_valid) begin // RULE6 RULE13
          next_s.addr = addr_s;
          next_s.wdata = wide ? data_s : {8'h00, data_s[7:0]}; // RULE3
          next_s.is_read = want_rd;
          next_s.core_we = !want_rd;
          if (!accept) begin
            next_s.st = DHP_IGNORE; // RULE18
          end else if (addr_s > DHP_MAP_LAST) begin
            // beyond the map nothing ever completes; ready stays low
            next_s.st = DHP_HANG; // RULE10
            next_s.hs_oe = !single; // RULE8
          end else if (is_local) begin
            if (!want_rd) begin
              next_s.hac = data_s[7:0]; // RULE2
            end
            next_s.st = DHP_DONE;
            // ready dips even here, else a separate-style host cannot tell started from done
            next_s.hs_oe = 1'b1; // RULE8 RULE15 RULE16
            next_s.d_out = {8'h00, s.hac}; // RULE12
            next_s.d_oe = dhp_lane_en(want_rd, wide); // RULE3 RULE20
          end else begin
            // output data words live in the core map and go the same way
            next_s.st = DHP_CORE; // RULE2 RULE19
            next_s.core_req = 1'b1;
            next_s.hs_oe = !single; // RULE8
          end
        end
      end
      DHP_CORE: begin
        next_s.hs_oe = s.hs_oe && port_on; // RULE1
        if (core_ack) begin
          if (port_on) begin
            next_s.st = DHP_DONE;
            next_s.hs_oe = single; // RULE8 RULE15 RULE16 RULE17
            next_s.d_out = wide ? core_rdata : {8'h00, core_rdata[7:0]}; // RULE3 RULE12
            next_s.d_oe = dhp_lane_en(s.is_read, wide); // RULE17 RULE20
          end else begin
            next_s.st = DHP_IDLE;
          end
        end
      end
      DHP_DONE: begin
        if (cs_n_s || !port_on || (single && strb_b_s)) begin // RULE15
          next_s.st = DHP_IDLE;
          next_s.hs_oe = 1'b0;
          next_s.d_oe = 16'h0000; // RULE20
        end else if (!single) begin
          // a local access holds ready low for one cycle, then releases it
          next_s.hs_oe = 1'b0; // RULE8
        end
      end
      DHP_HANG, DHP_IGNORE: begin
        if (cs_n_s || !port_on) begin
          next_s.st = DHP_IDLE;
          next_s.hs_oe = 1'b0;
        end else begin
          next_s.hs_oe = s.hs_oe;
        end
      end
      default: begin
        next_s.st = DHP_IDLE;
        next_s.hs_oe = 1'b0;
        next_s.d_oe = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= DHP_IDLE;
      s.hac <= DHP_HAC_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign data_out = s.d_out;
  assign data_oe = s.d_oe;
  assign transfer_acknowledge_out = s.hs_out;
  assign transfer_acknowledge_oe = s.hs_oe;
  assign core_req = s.core_req;
  assign core_we = s.core_we;
  assign core_addr = s.addr;
  assign core_wdata = s.wdata;
  assign core_wide = s.hac[DHP_HAC_WIDE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dhp_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start;
    (s.st == DHP_IDLE) ##1 (s.st != DHP_IDLE);
  endsequence

  sequence s_core_finish;
    (s.st == DHP_CORE) && core_ack && port_on;
  endsequence

  property p_port_off_released;
    !port_on && s.st != DHP_CORE |=> !s.hs_oe && (s.d_oe == 16'h0000);
  endproperty
  a_port_off_released: assert property (p_port_off_released) // RULE1
    else $error("pins driven while port deselected");

  property p_start_on_edge;
    s_start |-> $past(hrise) && !$past(cs_n_s);
  endproperty
  a_start_on_edge: assert property (p_start_on_edge) // RULE6
    else $error("access started without host clock edge and select");

  property p_core_pulse;
    s.core_req |-> (s.st == DHP_CORE) ##1 !s.core_req;
  endproperty
  a_core_pulse: assert property (p_core_pulse) // RULE2
    else $error("core request not a single pulse");

  property p_narrow_lanes;
    !s.hac[DHP_HAC_WIDE_BIT] |-> (s.d_oe[15:8] == 8'h00) && (s.d_out[15:8] == 8'h00);
  endproperty
  a_narrow_lanes: assert property (p_narrow_lanes) // RULE3
    else $error("upper lanes used in 8-bit mode");

  property p_ready_during_access;
    !single && (s.st == DHP_CORE) && port_on |-> s.hs_oe;
  endproperty
  a_ready_during_access: assert property (p_ready_during_access) // RULE8
    else $error("ready not held low during access");

  property p_ready_release;
    s_core_finish ##0 !single |=> (s.st == DHP_DONE) && !s.hs_oe;
  endproperty
  a_ready_release: assert property (p_ready_release) // RULE8
    else $error("ready not released at completion");

  property p_open_drain;
    !s.hs_out;
  endproperty
  a_open_drain: assert property (p_open_drain) // RULE9
    else $error("handshake line driven high");

  property p_ack_done;
    s_core_finish ##0 single |=> s.hs_oe ##0 (s.d_oe == dhp_lane_en(s.is_read, wide));
  endproperty
  a_ack_done: assert property (p_ack_done) // RULE17
    else $error("acknowledge or read data missing at completion");

  property p_ack_release;
    (s.st == DHP_DONE) && single && strb_b_s |=> !s.hs_oe && (s.st == DHP_IDLE);
  endproperty
  a_ack_release: assert property (p_ack_release) // RULE15
    else $error("acknowledge held after strobe release");

  property p_ignore_silent;
    (s.st == DHP_IGNORE) |-> !s.hs_oe && (s.d_oe == 16'h0000) && !s.core_req;
  endproperty
  a_ignore_silent: assert property (p_ignore_silent) // RULE18
    else $error("ignored access touched the bus");

  property p_oe_only_read;
    (s.d_oe != 16'h0000) |-> s.is_read && (s.st == DHP_DONE);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) // RULE20
    else $error("data bus driven outside a read");

  property p_hang_never_done;
    (s.st == DHP_HANG) && !cs_n_s && port_on |=> (s.st == DHP_HANG);
  endproperty
  a_hang_never_done: assert property (p_hang_never_done) // RULE10
    else $error("access beyond map completed");

  property p_local_ready_pulse;
    !single && (s.st == DHP_DONE) && s.hs_oe |=> !s.hs_oe;
  endproperty
  a_local_ready_pulse: assert property (p_local_ready_pulse) // RULE8
    else $error("ready held low after a local access completed");

  property p_narrow_write_data;
    s.core_req && !s.hac[DHP_HAC_WIDE_BIT] |-> (s.wdata[15:8] == 8'h00);
  endproperty
  a_narrow_write_data: assert property (p_narrow_write_data) // RULE3
    else $error("upper data lines passed on in 8-bit mode");

  property p_release_on_select;
    (s.st == DHP_DONE) && cs_n_s |=> (s.st == DHP_IDLE) && !s.hs_oe && (s.d_oe == 16'h0000);
  endproperty
  a_release_on_select: assert property (p_release_on_select) // RULE20
    else $error("bus still driven after chip select released");

endmodule // dhp_host_port

// ---- rtl/dhp_pkg.sv ----
// shared constants, types and helpers for the dual-style host port
package dhp_pkg;

  // register map
  localparam logic [7:0] DHP_HAC_OFFSET = 8'h02;
  localparam logic [7:0] DHP_HAC_RESET = 8'h00;
  localparam logic [7:0] DHP_MAP_LAST = 8'hE7;
  localparam int DHP_HAC_ID_LSB = 0;
  localparam int DHP_HAC_WIDE_BIT = 7;

  // bus widths and synchroniser depth
  localparam int DHP_ADDR_W = 8;
  localparam int DHP_DATA_W = 16;
  localparam int DHP_ID_W = 4;
  localparam int DHP_SYNC_STAGES = 2;

  // host bus clock ceiling, kept by the host
  localparam int DHP_HOST_CLK_MAX_MHZ = 100;

  typedef enum logic {
    DHP_SEPARATE_STROBE_STYLE = 1'h0,
    DHP_SINGLE_STROBE_STYLE = 1'h1
  } dhp_style_t;

  typedef enum logic [4:0] {
    DHP_IDLE = 5'h01,
    DHP_CORE = 5'h02,
    DHP_DONE = 5'h04,
    DHP_HANG = 5'h08,
    DHP_IGNORE = 5'h10
  } dhp_state_t;

  // byte lanes the device drives for an access
  function automatic logic [15:0] dhp_lane_en(input logic is_read, input logic wide);
    logic [15:0] lanes;
    lanes = 16'h0000;
    if (is_read) begin
      lanes = wide ? 16'hFFFF : 16'h00FF;
    end
    return lanes;
  endfunction

endpackage

// ---- rtl/dhp_sync.sv ----
// two-stage synchroniser for the host port pins
`timescale 1ns/1ps
module dhp_sync import dhp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  if (W < 1) begin : g_bad_width
    $error("dhp_sync: width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dhp_sync_regs_t;

  dhp_sync_regs_t s;
  dhp_sync_regs_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // the first stage is read only by the second stage
  always_comb begin
    next_s = s;
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s.meta <= RST_VAL;
      s.stable <= RST_VAL;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule // dhp_sync

// ---- tb/dhp_host_model.sv ----
// bus master model: drives the host port pins in either strobe style
`timescale 1ns/1ps
module dhp_host_model import dhp_pkg::*; (
  input wire logic core_clk,
  input wire logic ack_line,
  input wire logic [DHP_DATA_W-1:0] bus_in,
  output logic host_bus_clock,
  output logic chip_sel_n,
  output logic wr_n_or_dir,
  output logic rd_n_or_data_valid_strobe_n,
  output logic [DHP_ADDR_W-1:0] host_addr,
  output logic [DHP_DATA_W-1:0] host_data,
  output logic host_drive
);
  // free running, well below both the core clock and the ceiling
  initial begin
    host_bus_clock = 1'b0;
    forever #80 host_bus_clock = ~host_bus_clock;
  end
  initial begin
    chip_sel_n = 1'b1;
    wr_n_or_dir = 1'b1;
    rd_n_or_data_valid_strobe_n = 1'b1;
    host_addr = 8'h00;
    host_data = 16'h0000;
    host_drive = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // refused accesses never handshake, so every wait is bounded
  task automatic access(input logic single, input logic we, input logic [7:0] addr,
      input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
    int n;
    logic low_seen;
    n = 0;
    @(negedge core_clk);
    host_addr = addr;
    host_data = wdata;
    host_drive = we;
    if (single) begin
      wr_n_or_dir = ~we;
      rd_n_or_data_valid_strobe_n = 1'b0;
    end else if (we) begin
      wr_n_or_dir = 1'b0;
    end else begin
      rd_n_or_data_valid_strobe_n = 1'b0;
    end
    @(negedge core_clk);
    chip_sel_n = 1'b0;
    // sampled mid-cycle, never in the step of the edge that launches the line
    while (ack_line !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    low_seen = (ack_line === 1'b0);
    while (!single && low_seen && ack_line !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    ok = low_seen && (single || ack_line === 1'b1);
    rdata = bus_in;
    @(negedge core_clk);
    chip_sel_n = 1'b1;
    wr_n_or_dir = 1'b1;
    rd_n_or_data_valid_strobe_n = 1'b1;
    host_drive = 1'b0;
    n = 0;
    while (ack_line !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    ok = ok && ack_line === 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
endmodule // dhp_host_model

// ---- tb/dhp_host_port_bench.sv ----
// self-checking bench for the dual-style host port
`timescale 1ns/1ps
module dhp_host_port_bench import dhp_pkg::*;;
  `define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    error_cnt++; $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
  logic core_clk, rst_n, port_select_pin, bus_style_pin, host_bus_clock, chip_sel_n;
  logic wr_n_or_dir, rd_n_or_data_valid_strobe_n, host_drive, ack_out, ack_oe, ack_line;
  logic core_req, core_we, core_wide, core_ack, pend, last_wide, ok;
  logic [7:0] host_addr, core_addr, last_addr;
  logic [15:0] host_data, data_in, data_out, data_oe, core_wdata, core_rdata, rd, flt;
  logic [15:0] last_wdata;
  logic [15:0] mem [256];
  int error_cnt, comparisons, cycles, req_cnt, core_lat, wait_cnt, r0;
  // open-drain line with a pull-up; an undriven data bus wanders
  assign ack_line = ack_oe ? ack_out : 1'b1;
  assign data_in = host_drive ? host_data : flt;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  dhp_host_model host (.core_clk(core_clk), .ack_line(ack_line),
    .bus_in((data_out & data_oe) | (flt & ~data_oe)), .host_bus_clock(host_bus_clock),
    .chip_sel_n(chip_sel_n), .wr_n_or_dir(wr_n_or_dir),
    .rd_n_or_data_valid_strobe_n(rd_n_or_data_valid_strobe_n), .host_addr(host_addr),
    .host_data(host_data), .host_drive(host_drive));
  dhp_host_port dut (.core_clk(core_clk), .rst_n(rst_n), .port_select_pin(port_select_pin),
    .bus_style_pin(bus_style_pin), .host_bus_clock(host_bus_clock), .chip_sel_n(chip_sel_n),
    .wr_n_or_dir(wr_n_or_dir), .rd_n_or_data_valid_strobe_n(rd_n_or_data_valid_strobe_n),
    .host_addr(host_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .transfer_acknowledge_out(ack_out), .transfer_acknowledge_oe(ack_oe),
    .board_identity_pins(4'h5), .core_req(core_req), .core_we(core_we),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_wide(core_wide),
    .core_ack(core_ack), .core_rdata(core_rdata));
  //////////////////////////////////////////////////////////////////////////////
  // core side register store, answers after core_lat idle cycles
  initial begin
    core_ack = 1'b0;
    core_rdata = 16'h0000;
    pend = 1'b0;
    flt = 16'h5AC3;
  end
  always @(posedge core_clk) begin
    flt <= ~flt;
    core_ack <= 1'b0;
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      finish_test();
    end
    if (core_req) begin
      req_cnt++;
      pend <= 1'b1;
      wait_cnt <= core_lat;
      last_addr <= core_addr;
      last_wide <= core_wide;
      last_wdata <= core_wdata;
      if (core_we) mem[core_addr] <= core_wdata;
    end else if (pend && wait_cnt == 0) begin
      core_ack <= 1'b1;
      core_rdata <= mem[last_addr];
      pend <= 1'b0;
    end else if (pend) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    port_select_pin = 1'b0;
    bus_style_pin = 1'b0;
    core_lat = 0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK("oe after reset", 16'h0000, data_oe)
    `CHK("ack after reset", 1'b0, ack_oe)
    host.access(1'b0, 1'b0, 8'h02, 16'h0000, rd, ok);
    `CHK("foreign read refused", 1'b0, ok)
    for (int s = 0; s < 2; s++) begin
      bus_style_pin = s[0];
      host.access(s[0], 1'b1, 8'h02, 16'h0005, rd, ok);
      host.access(s[0], 1'b0, 8'h02, 16'h0000, rd, ok);
      `CHK("control readback", 8'h05, rd[7:0])
      host.access(s[0], 1'b1, 8'h10, 16'h1234, rd, ok);
      `CHK("narrow write ok", 1'b1, ok)
      `CHK("narrow write byte", 17'h00034, {last_wide, last_wdata})
      host.access(s[0], 1'b0, 8'h10, 16'h0000, rd, ok);
      `CHK("narrow read", 9'h134, {ok, rd[7:0]})
      host.access(s[0], 1'b1, 8'h02, 16'h0085, rd, ok);
      core_lat = 3;
      host.access(s[0], 1'b1, 8'hE7, 16'hBEEF, rd, ok);
      host.access(s[0], 1'b0, 8'hE7, 16'h0000, rd, ok);
      `CHK("wide read", 18'h3BEEF, {ok, last_wide, rd})
      `CHK("bus floats when idle", 16'h0000, data_oe)
      core_lat = 0;
      host.access(s[0], 1'b0, 8'hE8, 16'h0000, rd, ok);
      `CHK("beyond map hangs", 1'b0, ok)
      $display("test style %0d done", s);
    end
    r0 = req_cnt;
    port_select_pin = 1'b1;
    repeat (5) @(negedge core_clk);
    host.access(1'b1, 1'b0, 8'h10, 16'h0000, rd, ok);
    `CHK("deselected port", 33'h000000000, {ok, req_cnt - r0})
    port_select_pin = 1'b0;
    repeat (5) @(negedge core_clk);
    host.access(1'b1, 1'b1, 8'h02, 16'h0003, rd, ok);
    r0 = req_cnt;
    host.access(1'b1, 1'b0, 8'h10, 16'h0000, rd, ok);
    `CHK("identity mismatch", 33'h000000000, {ok, req_cnt - r0})
    $display("test refusals done");
    finish_test();
  end
endmodule // dhp_host_port_bench
